// ===== dual_timer_pkg.sv
package dual_timer_pkg;
   // channel count
   localparam int NUM_CH = 2;

   // time settings are hundredths of a unit, 0 .. 650.00
   localparam int TIME_W = 16;
   localparam logic [TIME_W-1:0] TIME_MAX = 16'hFDE8;
   localparam logic [TIME_W-1:0] TIME_RST = 16'h0000;

   // mode code register
   localparam int MODE_W = 8;
   localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
   localparam logic [7:0] MODE_UNIT_MIN = 8'h64;
   localparam logic [7:0] MODE_UNIT_HR = 8'hC8;
   localparam logic [7:0] MODE_FALL_OFS = 8'h0A;

   // register map (word index equals printed offset)
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] REG_MODE0 = 4'h0;
   localparam logic [ADDR_W-1:0] REG_DELAY0 = 4'h1;
   localparam logic [ADDR_W-1:0] REG_DUR0 = 4'h2;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h3;
   localparam logic [ADDR_W-1:0] REG_MODE1 = 4'h4;
   localparam logic [ADDR_W-1:0] REG_DELAY1 = 4'h5;
   localparam logic [ADDR_W-1:0] REG_DUR1 = 4'h6;
   localparam int DATA_W = 32;

   // time base: hundredth of a second at 200 MHz
   localparam int CLK_HZ = 200000000;
   localparam int TICK_PER_SEC = 100;
   localparam int SEC_CYCLES = CLK_HZ / TICK_PER_SEC;
   localparam int MIN_PER_SEC = 60;
   localparam int HR_PER_MIN = 60;

   typedef enum logic [1:0] {
      BEH_OFF = 2'b00,
      BEH_NORMAL = 2'b01,
      BEH_RETRIG = 2'b10,
      BEH_AND = 2'b11
   } beh_t;

   typedef enum logic [1:0] {
      UNIT_SEC = 2'b00,
      UNIT_MIN = 2'b01,
      UNIT_HR = 2'b10
   } unit_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DELAY = 2'b01,
      ST_ON = 2'b10,
      ST_HOLD = 2'b11
   } chan_state_t;
endpackage

// ===== tick_if.sv
`timescale 1ns/1ps
interface tick_if;
   logic tick_sec;
   logic tick_min;
   logic tick_hr;
   modport src (output tick_sec, output tick_min, output tick_hr);
   modport dst (input tick_sec, input tick_min, input tick_hr);
endinterface

// ===== time_base.sv
`timescale 1ns/1ps
module time_base
   import dual_timer_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // hundredth-of-unit ticks
   tick_if.src tk
);
   logic [31:0] div_q;
   logic [5:0] sec_q;
   logic [5:0] min_q;

   // hundredth of a second
   always_ff @(posedge clk) begin
      if (rst) begin
         div_q <= 32'h0000_0000;
         tk.tick_sec <= 1'b0;
      end else if (div_q == 32'(SEC_CYCLES - 1)) begin
         div_q <= 32'h0000_0000;
         tk.tick_sec <= 1'b1;
      end else begin
         div_q <= div_q + 32'h0000_0001;
         tk.tick_sec <= 1'b0;
      end
   end

   // minutes and hours cascade from the second tick
   always_ff @(posedge clk) begin
      if (rst) begin
         sec_q <= 6'h00;
         min_q <= 6'h00;
         tk.tick_min <= 1'b0;
         tk.tick_hr <= 1'b0;
      end else begin
         tk.tick_min <= 1'b0;
         tk.tick_hr <= 1'b0;
         if (div_q == 32'(SEC_CYCLES - 1)) begin
            if (sec_q == 6'(MIN_PER_SEC - 1)) begin
               sec_q <= 6'h00;
               tk.tick_min <= 1'b1;
               if (min_q == 6'(HR_PER_MIN - 1)) begin
                  min_q <= 6'h00;
                  tk.tick_hr <= 1'b1;
               end else begin
                  min_q <= min_q + 6'h01;
               end
            end else begin
               sec_q <= sec_q + 6'h01;
            end
         end
      end
   end
endmodule

// ===== dual_delay_pulse_timer.sv
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - two channels, each with own mode, delay and duration settings
// - delay and duration 0 to 650.00 in hundredths, reset to zero
// - normal: edge starts delay, then output on for duration, then off
// - duration zero: output stays on after delay expires
// - retrigger and AND modes: edge during delay restarts the delay
// - AND mode: input dropping (rising in falling-edge modes) during duration clears output at once
// - AND mode: output stays on for whole duration while input holds
// - delay and duration both zero: output follows input directly, inverted in falling-edge modes
// - mode 0 off, 1..3 rising edge, 11..13 same on falling edge
// - mode 100s count minutes, 200s count hours, else seconds
// - off mode holds output low whatever the input does
module dual_delay_pulse_timer
   import dual_timer_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   // trigger inputs and timer outputs
   input wire logic [NUM_CH-1:0] sig_in,
   output logic [NUM_CH-1:0] sig_out
);
   tick_if tk ();

   logic [NUM_CH-1:0] in_s1_q;
   logic [NUM_CH-1:0] in_s2_q;
   logic [NUM_CH-1:0] in_prev_q;
   logic [MODE_W-1:0] mode_q [NUM_CH];
   logic [TIME_W-1:0] delay_q [NUM_CH];
   logic [TIME_W-1:0] dur_q [NUM_CH];
   chan_state_t st_q [NUM_CH];
   logic [TIME_W-1:0] cnt_q [NUM_CH];

   time_base u_tb (
      .clk(clk),
      .rst(rst),
      .tk(tk)
   );

   // pins cross in through two flops
   always_ff @(posedge clk) begin
      if (rst) begin
         in_s1_q <= '0;
         in_s2_q <= '0;
         in_prev_q <= '0;
      end else begin
         in_s1_q <= sig_in;
         in_s2_q <= in_s1_q;
         in_prev_q <= in_s2_q;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         localparam logic [ADDR_W-1:0] A_MODE = g ? REG_MODE1 : REG_MODE0;
         localparam logic [ADDR_W-1:0] A_DLY = g ? REG_DELAY1 : REG_DELAY0;
         localparam logic [ADDR_W-1:0] A_DUR = g ? REG_DUR1 : REG_DUR0;
         logic [7:0] base;
         logic [7:0] code;
         logic falling;
         beh_t beh;
         unit_t unit;
         logic utick;
         logic lvl;
         logic edge_hit;
         logic new_on;

         // per-channel settings, independent of the other channel
         always_ff @(posedge clk) begin
            if (rst) begin
               mode_q[g] <= MODE_RST;
               delay_q[g] <= TIME_RST;
               dur_q[g] <= TIME_RST;
            end else if (wr) begin
               if (addr == A_MODE) begin
                  mode_q[g] <= wdata[MODE_W-1:0];
               end
               // out-of-range times saturate at the top of the range
               if (addr == A_DLY) begin
                  delay_q[g] <= (wdata > 32'(TIME_MAX)) ? TIME_MAX : wdata[TIME_W-1:0];
               end
               if (addr == A_DUR) begin
                  dur_q[g] <= (wdata > 32'(TIME_MAX)) ? TIME_MAX : wdata[TIME_W-1:0];
               end
            end
         end

         // decode the mode code into unit, edge and behaviour
         always_comb begin
            if (mode_q[g] >= MODE_UNIT_HR) begin
               unit = UNIT_HR;
               base = mode_q[g] - MODE_UNIT_HR;
            end else if (mode_q[g] >= MODE_UNIT_MIN) begin
               unit = UNIT_MIN;
               base = mode_q[g] - MODE_UNIT_MIN;
            end else begin
               unit = UNIT_SEC;
               base = mode_q[g];
            end
            falling = (base > MODE_FALL_OFS);
            code = falling ? base - MODE_FALL_OFS : base;
            // unknown codes act as off
            case (code)
               8'h01: beh = BEH_NORMAL;
               8'h02: beh = BEH_RETRIG;
               8'h03: beh = BEH_AND;
               default: beh = BEH_OFF;
            endcase
            if (falling && base > 8'h0D) begin
               beh = BEH_OFF;
            end
            case (unit)
               UNIT_MIN: utick = tk.tick_min;
               UNIT_HR: utick = tk.tick_hr;
               default: utick = tk.tick_sec;
            endcase
            lvl = falling ? ~in_s2_q[g] : in_s2_q[g];
            edge_hit = lvl & ~(falling ? ~in_prev_q[g] : in_prev_q[g]);
            // duration end clears, zero duration latches on
            new_on = (dur_q[g] == TIME_RST) ? 1'b1 : 1'b0;
         end

         always_ff @(posedge clk) begin
            if (rst) begin
               st_q[g] <= ST_IDLE;
               cnt_q[g] <= TIME_RST;
               sig_out[g] <= 1'b0;
            end else if (beh == BEH_OFF) begin
               st_q[g] <= ST_IDLE;
               cnt_q[g] <= TIME_RST;
               sig_out[g] <= 1'b0;
            end else if (delay_q[g] == TIME_RST && dur_q[g] == TIME_RST) begin
               // zero settings make a plain follower
               st_q[g] <= ST_IDLE;
               cnt_q[g] <= TIME_RST;
               sig_out[g] <= lvl;
            end else begin
               case (st_q[g])
                  ST_IDLE: begin
                     if (edge_hit) begin
                        st_q[g] <= ST_DELAY;
                        cnt_q[g] <= TIME_RST;
                     end
                  end
                  ST_DELAY: begin
                     if (edge_hit && beh != BEH_NORMAL) begin
                        cnt_q[g] <= TIME_RST;
                     end else if (cnt_q[g] >= delay_q[g]) begin
                        sig_out[g] <= 1'b1;
                        cnt_q[g] <= TIME_RST;
                        st_q[g] <= new_on ? ST_HOLD : ST_ON;
                     end else if (utick) begin
                        cnt_q[g] <= cnt_q[g] + 16'h0001;
                     end
                  end
                  ST_ON: begin
                     if (beh == BEH_AND && !lvl) begin
                        sig_out[g] <= 1'b0;
                        st_q[g] <= ST_IDLE;
                     end else if (cnt_q[g] >= dur_q[g]) begin
                        sig_out[g] <= 1'b0;
                        st_q[g] <= ST_IDLE;
                     end else if (utick) begin
                        cnt_q[g] <= cnt_q[g] + 16'h0001;
                     end
                  end
                  ST_HOLD: begin
                     // stays on until the duration is set nonzero, the delay is set to zero or the mode turns off
                     sig_out[g] <= 1'b1;
                     if (dur_q[g] != TIME_RST) begin
                        st_q[g] <= ST_IDLE;
                        sig_out[g] <= 1'b0;
                     end
                  end
                  default: st_q[g] <= ST_IDLE;
               endcase
            end
         end
      end
   endgenerate

   // register read, one cycle later
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= '0;
      end else if (rd) begin
         case (addr)
            REG_MODE0: rdata <= {24'h000000, mode_q[0]};
            REG_DELAY0: rdata <= {16'h0000, delay_q[0]};
            REG_DUR0: rdata <= {16'h0000, dur_q[0]};
            REG_MODE1: rdata <= {24'h000000, mode_q[1]};
            REG_DELAY1: rdata <= {16'h0000, delay_q[1]};
            REG_DUR1: rdata <= {16'h0000, dur_q[1]};
            REG_STATUS: rdata <= {24'h000000, st_q[1], st_q[0], in_s2_q, sig_out};
            default: rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end
endmodule

// ===== dual_timer_sva.sv
`timescale 1ns/1ps
module dual_timer_sva
   import dual_timer_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [DATA_W-1:0] rdata,
   // channel pins
   input wire logic [NUM_CH-1:0] sig_in,
   input wire logic [NUM_CH-1:0] sig_out
);
   logic [NUM_CH-1:0] off_q;
   logic [ADDR_W-1:0] ra;
   // shadow of the off mode, only code zero is trusted
   always_ff @(posedge clk) begin
      if (rst) begin
         off_q <= '1;
      end else if (wr && addr == REG_MODE0) begin
         off_q[0] <= wdata[7:0] == 8'h00;
      end else if (wr && addr == REG_MODE1) begin
         off_q[1] <= wdata[7:0] == 8'h00;
      end
   end
   // address of the previous cycle, lines up with the registered read data
   always_ff @(posedge clk) begin
      ra <= addr;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_reset_out: assert property (disable iff (1'b0) rst |=> sig_out == '0)
      else $error("output high after reset");
   a_rdata_idle: assert property (!$past(rd) |-> rdata == '0)
      else $error("read data without read");
   a_unmapped_zero: assert property ($past(rd) && ra > REG_DUR1 |-> rdata == '0)
      else $error("unmapped read not zero");
   a_time_range: assert property ($past(rd) && ra != REG_STATUS && ra[1:0] != 2'b00
      && ra <= REG_DUR1 |-> rdata[31:16] == '0 && rdata[15:0] <= TIME_MAX)
      else $error("time setting out of range");
   a_mode_width: assert property ($past(rd) && ra[1:0] == 2'b00 && ra <= REG_MODE1
      |-> rdata[31:8] == '0)
      else $error("mode code too wide");
   a_status_out: assert property ($past(rd) && ra == REG_STATUS |-> rdata[1:0] == $past(sig_out))
      else $error("status disagrees with outputs");
   a_status_upper: assert property ($past(rd) && ra == REG_STATUS |-> rdata[31:8] == '0)
      else $error("status upper bits set");
   a_off_low: assert property ((off_q & $past(off_q, 3) & sig_out) == '0)
      else $error("output high in off mode");
   c_rise0: cover property ($rose(sig_out[0]));
   c_rise1: cover property ($rose(sig_out[1]));
   c_status: cover property ($past(rd) && ra == REG_STATUS);
   c_and_cut: cover property ($fell(sig_in[0]) ##[1:8] $fell(sig_out[0]));
endmodule

bind dual_delay_pulse_timer dual_timer_sva u_dual_timer_sva (.clk(clk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sig_in(sig_in), .sig_out(sig_out));

// ===== sig_source.sv
`timescale 1ns/1ps
module sig_source
   import dual_timer_pkg::*;
(
   // clock
   input wire logic clk,
   // requested levels
   input wire logic [NUM_CH-1:0] lvl,
   // source pins
   output logic [NUM_CH-1:0] sig
);
   // a plain logic source, clean levels only
   always_ff @(posedge clk) begin
      sig <= lvl;
   end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb
   import dual_timer_pkg::*;
;
   logic clk = 0;
   logic rst = 1;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr = 0;
   logic rd = 0;
   logic [DATA_W-1:0] rdata;
   logic [NUM_CH-1:0] lvl = '0;
   logic [NUM_CH-1:0] sig_in;
   logic [NUM_CH-1:0] sig_out;
   logic [DATA_W-1:0] d;
   logic [7:0] codes [9] = '{8'h01, 8'h02, 8'h03, 8'h65, 8'h66, 8'h67, 8'hC9, 8'hCA, 8'hCB};
   int miscompares = 0;
   int num_checks = 0;
   int cyc = 0;
   always #2.5 clk = ~clk;
   dual_delay_pulse_timer u_dual_delay_pulse_timer (.clk(clk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sig_in(sig_in), .sig_out(sig_out));
   sig_source u_sig_source (.clk(clk), .lvl(lvl), .sig(sig_in));
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   task rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1;
      v = rdata;
   endtask
   // sync and edge stages need a few cycles before the pin shows
   task pins(input logic [1:0] v, input logic [1:0] exp);
      @(posedge clk);
      lvl <= v;
      repeat (10) @(posedge clk);
      #1;
      chk("sig_out", {30'h0, exp}, {30'h0, sig_out});
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         summarize;
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      for (int i = 0; i < 8; i++) begin
         rd_reg(i[ADDR_W-1:0], d);
         chk("reset value", 32'h0, d);
      end
      wr_reg(REG_DELAY0, 32'h0000FFFF);
      rd_reg(REG_DELAY0, d);
      chk("delay0 sat", {16'h0, TIME_MAX}, d);
      wr_reg(REG_DUR1, 32'h0000FDE8);
      rd_reg(REG_DUR1, d);
      chk("dur1 max", 32'h0000FDE8, d);
      rd_reg(REG_DUR0, d);
      chk("dur0 apart", 32'h0, d);
      wr_reg(REG_DELAY0, 32'h0);
      wr_reg(REG_DUR1, 32'h0);
      wr_reg(4'h7, 32'h0000FFFF);
      rd_reg(4'h7, d);
      chk("unmapped", 32'h0, d);
      pins(2'b11, 2'b00);
      pins(2'b00, 2'b00);
      foreach (codes[i]) begin
         wr_reg(REG_MODE0, {24'h0, codes[i]});
         wr_reg(REG_MODE1, {24'h0, codes[i]});
         pins(2'b11, 2'b11);
         pins(2'b01, 2'b01);
         pins(2'b00, 2'b00);
      end
      wr_reg(REG_MODE0, 32'h0);
      pins(2'b11, 2'b10);
      rd_reg(REG_STATUS, d);
      chk("status", 32'h0000000E, d & 32'h0000000F);
      pins(2'b00, 2'b00);
      // long delay cannot expire within the run, so the output must stay low
      wr_reg(REG_DELAY0, 32'h00000005);
      wr_reg(REG_MODE0, 32'h00000001);
      pins(2'b01, 2'b00);
      // falling edge, zero delay: a long duration holds the output on
      wr_reg(REG_MODE0, 32'h0);
      wr_reg(REG_DELAY0, 32'h0);
      wr_reg(REG_DUR0, 32'h00000005);
      wr_reg(REG_MODE0, 32'h0000000B);
      pins(2'b00, 2'b01);
      pins(2'b01, 2'b01);
      // gated mode: the input drop cuts the duration short
      wr_reg(REG_MODE0, 32'h0);
      wr_reg(REG_MODE0, 32'h00000003);
      pins(2'b00, 2'b00);
      pins(2'b01, 2'b01);
      pins(2'b00, 2'b00);
      summarize;
   end
endmodule
